// *** include/flash_wp_defines.svh ***
`ifndef FLASH_WP_DEFINES_SVH
`define FLASH_WP_DEFINES_SVH

// ***************************************************************
// clock and timing
// ***************************************************************
`define MCLK_HZ        40000000
`define CYC_PER_US     (`MCLK_HZ / 1000000)
`define PUW_TIME_US    1000
`define PP_TIME_US     2000
`define SE_TIME_US     120000
`define CE_TIME_US     5500000
`define SW_TIME_US     10000
`define PUW_CYCLES     (`PUW_TIME_US * `CYC_PER_US)
`define PP_CYCLES      (`PP_TIME_US * `CYC_PER_US)
`define SE_CYCLES      (`SE_TIME_US * `CYC_PER_US)
`define CE_CYCLES      (`CE_TIME_US * `CYC_PER_US)
`define SW_CYCLES      (`SW_TIME_US * `CYC_PER_US)

// ***************************************************************
// status register layout and reset values
// ***************************************************************
`define STAT_BUSY_BIT  0
`define STAT_WL_BIT    1
`define STAT_PS_LSB    2
`define STAT_PS_MSB    4
`define STAT_LOCK_BIT  7
`define PROT_SEL_RESET 3'h0
`define LOCK_RESET     1'b0

// ***************************************************************
// frame lengths in bits and protection bounds
// ***************************************************************
`define OPCODE_BITS    12'h008
`define WSTAT_BITS     12'h010
`define ADDR_END_BITS  12'h020
`define PROG_MIN_BITS  12'h028
`define ARRAY_LAST     19'h7ffff
`define PROT_BOUND_1   19'h00fff
`define PROT_BOUND_2   19'h01fff
`define PROT_BOUND_3   19'h03fff
`define PROT_BOUND_4   19'h07fff
`define PROT_BOUND_5   19'h0ffff
`define PROT_BOUND_6   19'h3ffff

`endif

// *** include/flash_wp_pkg.sv ***
package flash_wp_pkg;

  // instruction codes as shifted in first
  typedef enum logic [7:0] {
    OP_WSTAT = 8'h01,
    OP_PROG  = 8'h02,
    OP_READ  = 8'h03,
    OP_WDIS  = 8'h04,
    OP_RSTAT = 8'h05,
    OP_WEN   = 8'h06,
    OP_FAST  = 8'h0b,
    OP_MFID  = 8'h90,
    OP_RELID = 8'hab,
    OP_PDOWN = 8'hb9,
    OP_CHIP  = 8'hc7,
    OP_SECT  = 8'hd8
  } opcode_t;

  // self-timed cycle in progress
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PROG  = 3'b001,
    ST_SECT  = 3'b010,
    ST_CHIP  = 3'b011,
    ST_WSTAT = 3'b100
  } op_state_t;

  typedef struct packed {
    logic       status_lock;
    logic [1:0] reserved;
    logic [2:0] protect_sel;
    logic       write_latch;
    logic       busy;
  } status_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [11:0] nbits;
  } frame_t;

endpackage

// *** design/serial_flash_write_protect.sv ***
`timescale 1ns/1ps
`include "flash_wp_defines.svh"
module serial_flash_write_protect
  import flash_wp_pkg::*;
#(
  parameter logic        TOP_BOOT   = 1'b0,
  parameter logic [7:0]  MAKER_CODE = 8'ha5,  // arbitrary value
  parameter logic [7:0]  DEV_BOTTOM = 8'h5a,  // arbitrary value
  parameter logic [7:0]  DEV_TOP    = 8'h6b,  // arbitrary value
  parameter logic [31:0] PUW_CYCLES = `PUW_CYCLES,
  parameter logic [31:0] PP_CYCLES  = `PP_CYCLES,
  parameter logic [31:0] SE_CYCLES  = `SE_CYCLES,
  parameter logic [31:0] CE_CYCLES  = `CE_CYCLES,
  parameter logic [31:0] SW_CYCLES  = `SW_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        sclk,
  input  wire logic        cs_b,
  input  wire logic        serial_in,
  input  wire logic        wp_b,
  output logic             serial_out,
  output logic             serial_out_oe,
  output op_state_t        array_op,
  output logic [23:0]      array_addr,
  output logic             powered_down
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  if (PUW_CYCLES == 32'h0 || PP_CYCLES == 32'h0 || SE_CYCLES == 32'h0 ||
      CE_CYCLES == 32'h0 || SW_CYCLES == 32'h0) begin : g_bad_timing
    $error("cycle counts must be at least one");
  end

  // ***************************************************************
  // helpers
  // ***************************************************************
  // range check
  function automatic logic addr_protected(input logic [2:0]  sel,
                                          input logic [23:0] addr,
                                          input logic        top);
    logic [18:0] bound;
    bound = 19'h0;
    case (sel)
      3'h1: bound = `PROT_BOUND_1;
      3'h2: bound = `PROT_BOUND_2;
      3'h3: bound = `PROT_BOUND_3;
      3'h4: bound = `PROT_BOUND_4;
      3'h5: bound = `PROT_BOUND_5;
      3'h6: bound = `PROT_BOUND_6;
      3'h7: bound = `ARRAY_LAST;
      default: bound = 19'h0;
    endcase
    if (sel == 3'h0) begin
      return 1'b0;
    end else if (top) begin
      // top range mirrors the bottom one
      return addr[18:0] >= (`ARRAY_LAST - bound);
    end else begin
      return addr[18:0] <= bound;
    end
  endfunction

  // ***************************************************************
  // link domain: shift in on rising sclk
  // ***************************************************************
  logic        fresh_reg;
  logic [11:0] bit_cnt_reg;
  logic [11:0] bit_cnt_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [7:0]  opcode_reg;
  logic [23:0] addr_reg;
  logic        past_hdr_reg;
  logic [8:0]  stat_meta_reg;
  logic [8:0]  stat_sync_reg;

  // a deselect marks the next edge as the first of a frame
  always_ff @(posedge sclk or posedge cs_b or negedge rst_b) begin
    if (!rst_b || cs_b) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  assign bit_cnt_next = fresh_reg ? 12'h001 : bit_cnt_reg + 12'h001;
  assign shift_next   = {shift_reg[6:0], serial_in};

  // count survives the frame end so the core can judge its length
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_reg <= 12'h0;
      shift_reg   <= 8'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
    end
  end

  // opcode first, then three address bytes, MSB first
  // header only: a wrapped counter in a long read must not reload the opcode
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      opcode_reg <= 8'h0;
      addr_reg   <= 24'h0;
    end else if (bit_cnt_next[2:0] == 3'h0 && !past_hdr_reg) begin
      case (bit_cnt_next[11:3])
        9'h001: opcode_reg      <= shift_next;
        9'h002: addr_reg[23:16] <= shift_next;
        9'h003: addr_reg[15:8]  <= shift_next;
        9'h004: addr_reg[7:0]   <= shift_next;
        default: ;
      endcase
    end
  end

  // header flag keeps long reads streaming after the counter wraps
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      past_hdr_reg <= 1'b0;
    end else if (fresh_reg) begin
      past_hdr_reg <= 1'b0;
    end else if (bit_cnt_next == `ADDR_END_BITS) begin
      past_hdr_reg <= 1'b1;
    end
  end

  // status and power-down into the link domain; refreshed during the opcode
  status_t     status_q;
  logic        pd_reg;
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      stat_meta_reg <= 9'h0;
      stat_sync_reg <= 9'h0;
    end else begin
      stat_meta_reg <= {pd_reg, status_q};
      stat_sync_reg <= stat_meta_reg;
    end
  end

  // ***************************************************************
  // link domain: shift out on falling sclk
  // ***************************************************************
  status_t     link_stat;
  logic        link_pd;
  logic        tx_valid;
  logic [7:0]  tx_byte;
  logic        hdr_done;

  assign link_stat = stat_sync_reg[7:0];
  assign link_pd   = stat_sync_reg[8];
  assign hdr_done  = past_hdr_reg || (bit_cnt_reg >= `ADDR_END_BITS);

  // pick the outgoing byte from the opcode and position
  always_comb begin
    tx_valid = 1'b0;
    tx_byte  = 8'h0;
    case (opcode_reg)
      OP_RSTAT: begin
        // status read stays usable while busy
        tx_valid = past_hdr_reg || (bit_cnt_reg >= `OPCODE_BITS);
        tx_byte  = link_stat;
      end
      OP_MFID: begin
        tx_valid = hdr_done && !link_stat.busy && !link_pd;
        tx_byte  = bit_cnt_reg[3] ? (TOP_BOOT ? DEV_TOP : DEV_BOTTOM) : MAKER_CODE;
      end
      OP_RELID: begin
        // the release opcode also reads the device code
        tx_valid = hdr_done && !link_stat.busy;
        tx_byte  = TOP_BOOT ? DEV_TOP : DEV_BOTTOM;
      end
      default: ;
    endcase
  end

  // driver held off in reset and released as soon as select rises
  always_ff @(negedge sclk or posedge cs_b or negedge rst_b) begin
    if (!rst_b || cs_b) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out    <= tx_byte[3'h7 - bit_cnt_reg[2:0]];
      serial_out_oe <= tx_valid && !fresh_reg;  // a mode 3 fall before the first rise sees stale words
    end
  end

  // ***************************************************************
  // core domain: pin synchronisers and frame end
  // ***************************************************************
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_prev_reg;
  logic wp_meta_reg;
  logic wp_sync_reg;
  logic frame_end;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      wp_meta_reg <= 1'b0;
      wp_sync_reg <= 1'b0;
    end else begin
      cs_meta_reg <= cs_b;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
      wp_meta_reg <= wp_b;
      wp_sync_reg <= wp_meta_reg;
    end
  end

  // frame words are stable once sclk has stopped behind a high select
  assign frame_end = cs_sync_reg && !cs_prev_reg;

  // ***************************************************************
  // core domain: power-up write delay
  // ***************************************************************
  logic [31:0] puw_cnt_reg;
  logic        puw_pending;

  // write-type commands wait out the delay after reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      puw_cnt_reg <= PUW_CYCLES;
    end else if (puw_cnt_reg != 32'h0) begin
      puw_cnt_reg <= puw_cnt_reg - 32'h1;
    end
  end

  assign puw_pending = puw_cnt_reg != 32'h0;

  // ***************************************************************
  // core domain: command decode at frame end
  // ***************************************************************
  frame_t    fr;
  op_state_t state_reg;
  logic      wl_reg;
  logic      lock_reg;
  logic [2:0] psel_reg;
  logic      busy;
  logic      whole;
  logic      idle_cmd;
  logic      can_write;
  logic      stat_locked;
  logic      tgt_prot;
  logic      start_wstat;
  logic      start_prog;
  logic      start_sect;
  logic      start_chip;
  logic      do_wen;
  logic      do_wdis;
  logic      do_pdown;
  logic      do_release;

  assign fr   = '{opcode: opcode_reg, addr: addr_reg, nbits: bit_cnt_reg};
  assign busy = state_reg != ST_IDLE;

  // write-type frames must hold whole bytes
  assign whole = (fr.nbits[2:0] == 3'h0) && (fr.nbits != 12'h0);
  // power-down and busy swallow ordinary commands
  assign idle_cmd = frame_end && !busy && !pd_reg;
  // latch and delay gate every write-type command
  assign can_write = idle_cmd && whole && wl_reg && !puw_pending;
  // lock only bites with the pin low
  assign stat_locked = lock_reg && !wp_sync_reg;
  assign tgt_prot    = addr_protected(psel_reg, fr.addr, TOP_BOOT);

  assign start_wstat = can_write && fr.opcode == OP_WSTAT && fr.nbits >= `WSTAT_BITS && !stat_locked;
  assign start_prog  = can_write && fr.opcode == OP_PROG && fr.nbits >= `PROG_MIN_BITS && !tgt_prot;
  assign start_sect  = can_write && fr.opcode == OP_SECT && fr.nbits == `ADDR_END_BITS && !tgt_prot;
  assign start_chip  = can_write && fr.opcode == OP_CHIP && fr.nbits == `OPCODE_BITS && psel_reg == 3'h0;
  assign do_wen      = idle_cmd && whole && !puw_pending && fr.opcode == OP_WEN;
  assign do_wdis     = idle_cmd && whole && fr.opcode == OP_WDIS;
  assign do_pdown    = idle_cmd && whole && fr.opcode == OP_PDOWN;
  assign do_release  = frame_end && !busy && pd_reg && fr.opcode == OP_RELID && fr.nbits >= `OPCODE_BITS;

  // ***************************************************************
  // core domain: self-timed cycle
  // ***************************************************************
  logic [31:0] busy_cnt_reg;
  logic [7:0]  pend_reg;
  logic        op_done;

  assign op_done = busy && (busy_cnt_reg == 32'h0);

  // busy lasts for the cycle time of the started operation
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= ST_IDLE;
      busy_cnt_reg <= 32'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_wstat) begin
            state_reg    <= ST_WSTAT;
            busy_cnt_reg <= SW_CYCLES - 32'h1;
          end else if (start_prog) begin
            state_reg    <= ST_PROG;
            busy_cnt_reg <= PP_CYCLES - 32'h1;
          end else if (start_sect) begin
            state_reg    <= ST_SECT;
            busy_cnt_reg <= SE_CYCLES - 32'h1;
          end else if (start_chip) begin
            state_reg    <= ST_CHIP;
            busy_cnt_reg <= CE_CYCLES - 32'h1;
          end
        end
        ST_PROG, ST_SECT, ST_CHIP, ST_WSTAT: begin
          if (busy_cnt_reg == 32'h0) begin
            state_reg <= ST_IDLE;
          end else begin
            busy_cnt_reg <= busy_cnt_reg - 32'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // target address handed to the array while the cycle runs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      array_addr <= 24'h0;
    end else if (start_prog || start_sect) begin
      array_addr <= fr.addr;
    end
  end

  assign array_op = state_reg;

  // ***************************************************************
  // core domain: status register
  // ***************************************************************
  // latch set by enable, cleared by disable or completion
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wl_reg <= 1'b0;
    end else if (op_done) begin
      wl_reg <= 1'b0;
    end else if (do_wen) begin
      wl_reg <= 1'b1;
    end else if (do_wdis) begin
      wl_reg <= 1'b0;
    end
  end

  // only lock and selector take the written byte, at completion
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= 8'h0;
    end else if (start_wstat) begin
      pend_reg <= fr.addr[23:16];
    end
  end

  // selector and lock come up at their shipped value
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lock_reg <= `LOCK_RESET;
      psel_reg <= `PROT_SEL_RESET;
    end else if (op_done && state_reg == ST_WSTAT) begin
      lock_reg <= pend_reg[`STAT_LOCK_BIT];
      psel_reg <= pend_reg[`STAT_PS_MSB:`STAT_PS_LSB];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pd_reg <= 1'b0;
    end else if (do_pdown) begin
      pd_reg <= 1'b1;
    end else if (do_release) begin
      pd_reg <= 1'b0;
    end
  end

  // latch at bit one, reserved bits read as zero
  assign status_q     = '{status_lock: lock_reg, reserved: 2'b00, protect_sel: psel_reg,
                          write_latch: wl_reg, busy: busy};
  assign powered_down = pd_reg;

  // ***************************************************************
  // assertions
  // ***************************************************************
  // helper: busy spell measured apart from the down-counter
  logic [31:0] busy_len_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy_len_reg <= 32'h0;
    end else if (busy) begin
      busy_len_reg <= busy_len_reg + 32'h1;
    end else begin
      busy_len_reg <= 32'h0;
    end
  end

  // expected busy length of each self-timed cycle
  function automatic logic [31:0] cycle_len(input op_state_t op);
    case (op)
      ST_PROG:  return PP_CYCLES;
      ST_SECT:  return SE_CYCLES;
      ST_CHIP:  return CE_CYCLES;
      ST_WSTAT: return SW_CYCLES;
      default:  return 32'h0;
    endcase
  endfunction

  // bits six and five leave on the falls at byte positions one and two
  a_rsv_zero: assert property (@(posedge sclk) disable iff (!rst_b)
    serial_out_oe && opcode_reg == OP_RSTAT && (bit_cnt_reg[2:0] == 3'h1 || bit_cnt_reg[2:0] == 3'h2)
    |-> !serial_out) else $error("reserved status bit shifted out high");

  a_start_latch_set: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(busy) |-> $past(wl_reg) && wl_reg) else $error("cycle began without write latch");

  a_done_clears_latch: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(busy) |-> !wl_reg) else $error("write latch survived completion");

  a_puw_no_latch: assert property (@(posedge mclk) disable iff (!rst_b)
    puw_pending && !wl_reg |=> !wl_reg) else $error("latch set during power-up delay");

  a_pd_holds: assert property (@(posedge mclk) disable iff (!rst_b)
    pd_reg && !(frame_end && fr.opcode == OP_RELID) |=> pd_reg && $stable(wl_reg))
    else $error("power-down left by other opcode");

  a_lock_blocks: assert property (@(posedge mclk) disable iff (!rst_b)
    frame_end && !busy && stat_locked && fr.opcode == OP_WSTAT |=> !busy)
    else $error("locked status write accepted");

  a_prot_refuse: assert property (@(posedge mclk) disable iff (!rst_b)
    frame_end && !busy && tgt_prot && (fr.opcode == OP_PROG || fr.opcode == OP_SECT) |=> !busy)
    else $error("protected target accepted");

  a_frame_bound: assert property (@(posedge mclk) disable iff (!rst_b)
    frame_end && !busy && !whole |=> !busy && $stable(wl_reg)) else $error("partial byte frame acted");

  a_busy_ignores: assert property (@(posedge mclk) disable iff (!rst_b)
    busy && !op_done |=> $stable(wl_reg) && $stable(pd_reg) && $stable(psel_reg))
    else $error("command acted while busy");

  a_cycle_len: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(busy) |-> busy_len_reg == cycle_len($past(state_reg))) else $error("busy length wrong");

  c_wstat: cover property (@(posedge mclk) disable iff (!rst_b) start_wstat);
  c_prog:  cover property (@(posedge mclk) disable iff (!rst_b) start_prog);
  c_pd:    cover property (@(posedge mclk) disable iff (!rst_b) do_pdown ##[1:1000] do_release);

endmodule // serial_flash_write_protect

// *** sim/spi_host_model.sv ***
`timescale 1ns/1ps
// ********************
// spi host, mode 0
// ********************
module spi_host_model (
  output logic      sclk,
  output logic      cs_b,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  // link idles deselected with the clock parked low
  initial begin
    sclk      = 1'b0;
    cs_b      = 1'b1;
    serial_in = 1'b0;
  end

  task automatic xfer(input logic [47:0] bits, input int n, output logic [15:0] cap);
    cap = 16'h0000;
    #7 cs_b = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = bits[i];
      #62.5 sclk = 1'b1;
      cap = {cap[14:0], serial_out & serial_out_oe};  // undriven wire reads low
      #62.5 sclk = 1'b0;
    end
    #62.5 cs_b = 1'b1;
    serial_in = ~serial_in;  // stale data line must not look valid
  endtask
endmodule  // spi_host_model

// *** sim/serial_flash_write_protect_tb_top.sv ***
`timescale 1ns/1ps
// ********************
// bench top
// ********************
module serial_flash_write_protect_tb_top;
  import flash_wp_pkg::*;
  logic        mclk;
  logic        rst_b;
  logic        wp_b;
  logic        sclk;
  logic        cs_b;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_oe;
  op_state_t   array_op;
  logic [23:0] array_addr;
  logic        powered_down;
  logic        sclk_t;
  logic        cs_b_t;
  logic        serial_in_t;
  logic        serial_out_t;
  logic        serial_out_oe_t;
  op_state_t   array_op_t;
  logic [23:0] array_addr_t;
  logic        powered_down_t;
  logic [15:0] cap;
  logic [7:0]  st;
  int          error_cnt;
  int          compares;
  logic [23:0] bound [1:7] = '{24'h000fff, 24'h001fff, 24'h003fff, 24'h007fff,
                               24'h00ffff, 24'h03ffff, 24'h07ffff};

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // program and erase cycles kept long so the checks land inside them
  serial_flash_write_protect #(.PUW_CYCLES(32'd200), .PP_CYCLES(32'd400), .SE_CYCLES(32'd60),
    .CE_CYCLES(32'd60), .SW_CYCLES(32'd10)) dut (.mclk(mclk), .rst_b(rst_b), .sclk(sclk),
    .cs_b(cs_b), .serial_in(serial_in), .wp_b(wp_b), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .array_op(array_op), .array_addr(array_addr),
    .powered_down(powered_down));

  spi_host_model host (.sclk(sclk), .cs_b(cs_b), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe));

  // second part in the top organization, on a link of its own
  serial_flash_write_protect #(.TOP_BOOT(1'b1), .PUW_CYCLES(32'd200), .PP_CYCLES(32'd400),
    .SE_CYCLES(32'd60), .CE_CYCLES(32'd60), .SW_CYCLES(32'd10)) dut_top (.mclk(mclk), .rst_b(rst_b),
    .sclk(sclk_t), .cs_b(cs_b_t), .serial_in(serial_in_t), .wp_b(wp_b), .serial_out(serial_out_t),
    .serial_out_oe(serial_out_oe_t), .array_op(array_op_t), .array_addr(array_addr_t),
    .powered_down(powered_down_t));

  spi_host_model host_top (.sclk(sclk_t), .cs_b(cs_b_t), .serial_in(serial_in_t),
    .serial_out(serial_out_t), .serial_out_oe(serial_out_oe_t));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // frame words are read after frame end, so leave a gap
  task automatic tx(input logic [47:0] bits, input int n);
    host.xfer(bits, n, cap);
    repeat (12) @(posedge mclk);
  endtask

  task automatic tx_top(input logic [47:0] bits, input int n);
    host_top.xfer(bits, n, cap);
    repeat (12) @(posedge mclk);
  endtask

  task automatic rd_stat;
    tx(48'h0500, 16);
    st = cap[7:0];
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 1000 && array_op !== ST_IDLE; i++) begin
      @(posedge mclk);
    end
  endtask

  task automatic wstat(input logic [7:0] d);
    tx(48'h06, 8);
    tx({32'h0, 8'h01, d}, 16);
    wait_idle;
  endtask

  task automatic prog(input logic [23:0] a);
    tx(48'h06, 8);
    tx({8'h0, 8'h02, a, 8'h55}, 40);
  endtask

  initial begin
    #1000000;
    error_cnt++;
    complete_run;
  end

  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    error_cnt = 0;
    compares = 0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd_stat;
    check(24'(st), 24'h00);
    tx(48'h06, 8);
    rd_stat;
    check(24'(st), 24'h00);
    repeat (200) @(posedge mclk);
    tx(48'h06, 8);
    rd_stat;
    check(24'(st), 24'h02);
    tx(48'h04, 8);
    rd_stat;
    check(24'(st), 24'h00);
    prog(24'h000100);
    check(24'(array_op), 24'(ST_PROG));
    check(array_addr, 24'h000100);
    rd_stat;
    check(24'(st & 8'h01), 24'h01);
    tx(48'hb9, 8);
    tx(48'hc7, 8);
    check(24'(powered_down), 24'h0);
    check(24'(array_op), 24'(ST_PROG));
    wait_idle;
    rd_stat;
    check(24'(st), 24'h00);
    tx({8'h0, 8'h02, 24'h000200, 8'h55}, 40);
    check(24'(array_op), 24'(ST_IDLE));
    // walk selectors one to seven: bound refused, one past it accepted for one to six
    for (int s = 1; s < 8; s++) begin
      wstat({3'h0, 3'(s), 2'h0});
      prog(bound[s]);
      check(24'(array_op), 24'(ST_IDLE));
      rd_stat;
      check(24'(st), 24'({3'h0, 3'(s), 2'h2}));
      tx(48'h04, 8);
      if (s < 7) begin
        prog(bound[s] + 24'h1);
        check(24'(array_op), 24'(ST_PROG));
        wait_idle;
      end
    end
    wstat(8'hff);
    rd_stat;
    check(24'(st), 24'h9c);
    @(posedge mclk) wp_b <= 1'b0;
    wstat(8'h80);
    rd_stat;
    check(24'(st), 24'h9e);
    @(posedge mclk) wp_b <= 1'b1;
    wstat(8'h00);
    rd_stat;
    check(24'(st), 24'h00);
    @(posedge mclk) wp_b <= 1'b0;
    wstat(8'h04);
    rd_stat;
    check(24'(st), 24'h04);
    @(posedge mclk) wp_b <= 1'b1;
    tx(48'h06, 8);
    tx({31'h0, 8'h01, 8'h00, 1'b0}, 17);
    rd_stat;
    check(24'(st), 24'h06);
    tx(48'h04, 8);
    tx({8'h90, 40'h0}, 48);
    check(24'(cap), 24'ha55a);
    tx(48'hb9, 8);
    check(24'(powered_down), 24'h1);
    tx(48'h06, 8);
    tx({8'hab, 32'h0}, 40);
    check(24'(cap[7:0]), 24'h5a);
    check(24'(powered_down), 24'h0);
    rd_stat;
    check(24'(st), 24'h04);
    // erase paths while selector one guards the lowest 4 KB
    tx(48'h06, 8);
    tx(48'hc7, 8);
    check(24'(array_op), 24'(ST_IDLE));
    tx({8'hd8, 24'h000fff}, 32);
    check(24'(array_op), 24'(ST_IDLE));
    tx({8'hd8, 24'h001000}, 32);
    check(24'(array_op), 24'(ST_SECT));
    check(array_addr, 24'h001000);
    wait_idle;
    // reset in mid-run: a status read must get no answer
    @(posedge mclk) rst_b <= 1'b0;
    tx(48'h0500, 16);
    check(24'(cap), 24'h0000);
    @(posedge mclk) rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    rd_stat;
    check(24'(st), 24'h00);
    repeat (200) @(posedge mclk);
    tx(48'h06, 8);
    tx(48'hc7, 8);
    check(24'(array_op), 24'(ST_CHIP));
    wait_idle;
    rd_stat;
    check(24'(st), 24'h00);
    // top organization: selector one guards the last 4 KB
    tx_top(48'h06, 8);
    tx_top({32'h0, 8'h01, 8'h04}, 16);
    repeat (20) @(posedge mclk);
    tx_top(48'h06, 8);
    tx_top({8'h0, 8'h02, 24'h07f000, 8'h55}, 40);
    check(24'(array_op_t), 24'(ST_IDLE));
    tx_top({8'h0, 8'h02, 24'h07efff, 8'h55}, 40);
    check(24'(array_op_t), 24'(ST_PROG));
    check(array_addr_t, 24'h07efff);
    tx_top({8'hab, 32'h0}, 40);
    check(24'(cap[7:0]), 24'h00);
    for (int i = 0; i < 1000 && array_op_t !== ST_IDLE; i++) begin
      @(posedge mclk);
    end
    tx_top({8'hab, 32'h0}, 40);
    check(24'(cap[7:0]), 24'h6b);
    check(24'(powered_down_t), 24'h0);
    complete_run;
  end
endmodule  // serial_flash_write_protect_tb_top
